// ---- iae_irq_ctrl.v ----
// arm, enable and pending logic for trigger inputs and chain lines with AXI4-Lite access
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "iae_regs.vh"
module iae_irq_ctrl #(
    parameter N_TRIG  = 12,
    parameter N_CHAIN = 8
) (
    // clock and reset
    input  wire                aclk,
    input  wire                aresetn,
    // axi4-lite write address
    input  wire [7:0]          s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output reg                 s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output reg                 s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]          s_axi_bresp,
    output reg                 s_axi_bvalid,
    input  wire                s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]          s_axi_araddr,
    input  wire                s_axi_arvalid,
    output reg                 s_axi_arready,
    // axi4-lite read data
    output reg  [31:0]         s_axi_rdata,
    output reg  [1:0]          s_axi_rresp,
    output reg                 s_axi_rvalid,
    input  wire                s_axi_rready,
    // external trigger pins, asynchronous
    input  wire [N_TRIG-1:0]   trig_in,
    // chain-shared interrupt lines, open drain
    input  wire [N_CHAIN-1:0]  chain_shared_interrupt_in,
    output reg  [N_CHAIN-1:0]  chain_shared_interrupt_out,
    output reg  [N_CHAIN-1:0]  chain_shared_interrupt_oe,
    // timekeeping
    input  wire                pps_in,
    // host interrupt
    output reg                 host_irq,
    output reg  [4:0]          host_vector
);

localparam NS = N_TRIG + N_CHAIN;
localparam HOLD_CYC = (`IAE_HOLD_NS + `IAE_CLK_NS - 1) / `IAE_CLK_NS;

// three-stage synchronisers; stage 1 feeds only stage 2
reg  [NS-1:0] sync1_reg;
reg  [NS-1:0] sync2_reg;
reg  [NS-1:0] sync3_reg;
reg  [NS-1:0] level_reg;
reg  [2:0]    pps_sync_reg;
reg           pps_level_reg;

// software-visible control
reg  [NS-1:0] arm_reg;
reg  [NS-1:0] enable_reg;
reg  [NS-1:0] pend_reg;
reg  [NS-1:0] pend_next;
reg  [NS-1:0] mode_reg;
reg  [NS-1:0] pol_reg;
reg  [31:0]   route_reg;
reg  [31:0]   clock_reg;
reg  [31:0]   capture_reg;

// axi bookkeeping
reg           aw_hold_reg;
reg           w_hold_reg;
reg  [7:0]    awaddr_reg;
reg  [31:0]   wdata_reg;
reg  [3:0]    wstrb_reg;

wire [NS-1:0] raw_in = {chain_shared_interrupt_in, trig_in};
wire [NS-1:0] agree = ~(sync2_reg ^ sync3_reg);
wire [NS-1:0] level_next = (agree & sync3_reg) | (~agree & level_reg);
// polarity 1 = active high / rising edge, 0 = active low / falling edge
wire [NS-1:0] act_now = ~(level_next ^ pol_reg);
wire [NS-1:0] act_old = ~(level_reg ^ pol_reg);
// mode 0 edge, mode 1 level
wire [NS-1:0] hw_req = (act_now & ~act_old & ~mode_reg) | (act_now & mode_reg);
wire [NS-1:0] deliver = pend_reg & enable_reg;
// a write lands once, after both halves are held; acting on an offered
// but untaken half would clear or request pending bits several times
wire          wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
wire [7:0]    wr_addr = awaddr_reg;
wire [31:0]   wr_data = wdata_reg;
wire [3:0]    wr_strb = wstrb_reg;
// decode of the held write address
wire          hit_arm   = is_reg(wr_addr, `IAE_ARM_OFS);
wire          hit_en    = is_reg(wr_addr, `IAE_ENABLE_OFS);
wire          hit_pend  = is_reg(wr_addr, `IAE_PEND_OFS);
wire          hit_swreq = is_reg(wr_addr, `IAE_SWREQ_OFS);
wire          hit_mode  = is_reg(wr_addr, `IAE_MODE_OFS);
wire          hit_pol   = is_reg(wr_addr, `IAE_POL_OFS);
wire          hit_route = is_reg(wr_addr, `IAE_ROUTE_OFS);
wire          wr_known  = hit_arm | hit_en | hit_pend | hit_swreq
                          | hit_mode | hit_pol | hit_route;
// source registers widened to a bus word before byte merging
wire [31:0]   arm_wide  = {{(32-NS){1'b0}}, arm_reg};
wire [31:0]   en_wide   = {{(32-NS){1'b0}}, enable_reg};
wire [31:0]   mode_wide = {{(32-NS){1'b0}}, mode_reg};
wire [31:0]   pol_wide  = {{(32-NS){1'b0}}, pol_reg};
wire [31:0]   wr_merge_arm  = merge(arm_wide, wr_data, wr_strb);
wire [31:0]   wr_merge_en   = merge(en_wide, wr_data, wr_strb);
wire [31:0]   wr_merge_mode = merge(mode_wide, wr_data, wr_strb);
wire [31:0]   wr_merge_pol  = merge(pol_wide, wr_data, wr_strb);
// pulse-per-second rise, counted once stages two and three agree
wire          pps_rise = (pps_sync_reg[1] == pps_sync_reg[2]) & pps_sync_reg[2]
                         & ~pps_level_reg;

function [31:0] merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0]  strb;
    integer i;
    begin
        for (i = 0; i < 4; i = i + 1) begin
            merge[i*8 +: 8] = strb[i] ? val[i*8 +: 8] : old[i*8 +: 8];
        end
    end
endfunction

function is_reg;
    input [7:0] a;
    input [7:0] ofs;
    begin
        is_reg = (a[`IAE_OFS_MSB:2] == ofs[`IAE_OFS_MSB:2]);
    end
endfunction

// lowest-numbered pending source wins
function [4:0] prio;
    input [NS-1:0] v;
    integer i;
    begin
        prio = 5'h00;
        for (i = NS - 1; i >= 0; i = i - 1) begin
            if (v[i]) begin
                prio = i[4:0];
            end
        end
    end
endfunction

// synchronisers and filtered levels
always @(posedge aclk) begin
    if (!aresetn) begin
        sync1_reg     <= {NS{1'b0}};
        sync2_reg     <= {NS{1'b0}};
        sync3_reg     <= {NS{1'b0}};
        level_reg     <= {NS{1'b0}};
        pps_sync_reg  <= 3'h0;
        pps_level_reg <= 1'b0;
    end else begin
        sync1_reg     <= raw_in;
        sync2_reg     <= sync1_reg;
        sync3_reg     <= sync2_reg;
        level_reg     <= level_next;
        pps_sync_reg  <= {pps_sync_reg[1:0], pps_in};
        if (pps_sync_reg[1] == pps_sync_reg[2]) begin
            pps_level_reg <= pps_sync_reg[2];
        end
    end
end

// pending bits: set wins over a write-one clear in the same cycle; an arm write that disarms wins over set
always @* begin
    pend_next = pend_reg;
    if (wr_fire && is_reg(wr_addr, `IAE_PEND_OFS)) begin
        pend_next = pend_reg & ~wr_data[NS-1:0];
    end
    pend_next = pend_next | (hw_req & arm_reg);
    if (wr_fire && is_reg(wr_addr, `IAE_SWREQ_OFS)) begin
        // software request only marks local pending, chain untouched
        pend_next = pend_next | (wr_data[NS-1:0] & arm_reg);
    end
    pend_next = pend_next & arm_reg;
    if (wr_fire && is_reg(wr_addr, `IAE_ARM_OFS)) begin
        pend_next = pend_next & wr_merge_arm[NS-1:0];
    end
end

// axi write channel: each half accepted once, response after both
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_hold_reg   <= 1'b0;
        w_hold_reg    <= 1'b0;
        awaddr_reg    <= 8'h00;
        wdata_reg     <= 32'h00000000;
        wstrb_reg     <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `IAE_RESP_OKAY;
    end else begin
        // ready pulses one cycle, so a held half is never taken twice
        s_axi_awready <= ~aw_hold_reg & ~s_axi_awready & ~s_axi_bvalid;
        s_axi_wready  <= ~w_hold_reg & ~s_axi_wready & ~s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? `IAE_RESP_OKAY : `IAE_RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// control registers, loaded from the held write in the response cycle
always @(posedge aclk) begin
    if (!aresetn) begin
        arm_reg    <= {NS{1'b0}};
        enable_reg <= {NS{1'b0}};
        pend_reg   <= {NS{1'b0}};
        mode_reg   <= {NS{1'b0}};
        pol_reg    <= {NS{1'b1}};
        route_reg  <= 32'h00000000;
    end else begin
        pend_reg <= pend_next;
        if (wr_fire && hit_arm) begin
            arm_reg <= wr_merge_arm[NS-1:0];
        end
        if (wr_fire && hit_en) begin
            enable_reg <= wr_merge_en[NS-1:0];
        end
        if (wr_fire && hit_mode) begin
            mode_reg <= wr_merge_mode[NS-1:0];
        end
        if (wr_fire && hit_pol) begin
            pol_reg <= wr_merge_pol[NS-1:0];
        end
        if (wr_fire && hit_route) begin
            route_reg <= merge(route_reg, wr_data, wr_strb);
        end
    end
end

// free-running count and its capture; no interrupt sits in this path,
// so the captured value carries no handler latency
always @(posedge aclk) begin
    if (!aresetn) begin
        clock_reg   <= 32'h00000000;
        capture_reg <= 32'h00000000;
    end else begin
        clock_reg <= clock_reg + 32'h00000001;
        if (pps_rise) begin
            capture_reg <= clock_reg;
        end
    end
end

// read word and response for the presented read address
reg  [31:0]   rd_word;
reg  [1:0]    rd_resp;
always @* begin
    rd_word = 32'h00000000;
    rd_resp = `IAE_RESP_OKAY;
    if (is_reg(s_axi_araddr, `IAE_ARM_OFS)) begin
        rd_word[NS-1:0] = arm_reg;
    end else if (is_reg(s_axi_araddr, `IAE_ENABLE_OFS)) begin
        rd_word[NS-1:0] = enable_reg;
    end else if (is_reg(s_axi_araddr, `IAE_PEND_OFS)) begin
        rd_word[NS-1:0] = pend_reg;
    end else if (is_reg(s_axi_araddr, `IAE_MODE_OFS)) begin
        rd_word[NS-1:0] = mode_reg;
    end else if (is_reg(s_axi_araddr, `IAE_POL_OFS)) begin
        rd_word[NS-1:0] = pol_reg;
    end else if (is_reg(s_axi_araddr, `IAE_ROUTE_OFS)) begin
        rd_word = route_reg;
    end else if (is_reg(s_axi_araddr, `IAE_VECTOR_OFS)) begin
        rd_word = {26'h0000000, host_irq, host_vector};
    end else if (is_reg(s_axi_araddr, `IAE_CAPTURE_OFS)) begin
        rd_word = capture_reg;
    end else if (is_reg(s_axi_araddr, `IAE_CLOCK_OFS)) begin
        rd_word = clock_reg;
    end else if (!is_reg(s_axi_araddr, `IAE_SWREQ_OFS)) begin
        // request register is write-only and reads as zero
        rd_resp = `IAE_RESP_SLVERR;
    end
end

// axi read channel, one cycle after address accept
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= `IAE_RESP_OKAY;
    end else begin
        s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rd_resp;
            s_axi_rdata  <= rd_word;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

// host interrupt and chain drive
// route_reg[k]: trigger k drives chain line k; no arbitration between drivers
integer k;
always @(posedge aclk) begin
    if (!aresetn) begin
        host_irq                   <= 1'b0;
        host_vector                <= 5'h00;
        chain_shared_interrupt_out <= {N_CHAIN{1'b0}};
        chain_shared_interrupt_oe  <= {N_CHAIN{1'b0}};
    end else begin
        // one host line; the vector tells the handler which source it is
        host_irq    <= |deliver;
        host_vector <= prio(deliver);
        for (k = 0; k < N_CHAIN; k = k + 1) begin
            chain_shared_interrupt_out[k] <= 1'b0;
            // raw synchronised level, bypassing local arm/enable/pending
            if (k < N_TRIG) begin
                chain_shared_interrupt_oe[k] <= route_reg[k] & act_now[k];
            end else begin
                chain_shared_interrupt_oe[k] <= 1'b0;
            end
        end
    end
end

endmodule // iae_irq_ctrl

// ---- iae_regs.vh ----
// register map, field layout and timing constants of the interrupt arm/enable block
`ifndef IAE_REGS_VH
`define IAE_REGS_VH
`define IAE_ARM_OFS      8'h00
`define IAE_ENABLE_OFS   8'h04
`define IAE_PEND_OFS     8'h08
`define IAE_SWREQ_OFS    8'h0C
`define IAE_MODE_OFS     8'h10
`define IAE_POL_OFS      8'h14
`define IAE_ROUTE_OFS    8'h18
`define IAE_VECTOR_OFS   8'h1C
`define IAE_CAPTURE_OFS  8'h20
`define IAE_CLOCK_OFS    8'h24
`define IAE_OFS_MSB      7
`define IAE_CHAIN_LSB    16
`define IAE_RESP_OKAY    2'b00
`define IAE_RESP_SLVERR  2'b10
`define IAE_HOLD_NS      1500
`define IAE_CLK_NS       5
`endif

// ---- iae_ext_src.sv ----
// far-side trigger equipment and chain neighbours driving the block's inputs
`timescale 1ns/10ps
module iae_ext_src #(
    parameter HOLD = 300
) (
    input  wire        aclk,
    output logic [11:0] trig,
    output logic [7:0]  chain_pull
);
    initial begin
        trig = '0;
        chain_pull = '0;
    end
    // k below 12 is a trigger pin, from 12 up a chain line pulled low
    task drive(input int k, input logic v);
        @(posedge aclk);
        if (k < 12) trig[k] <= v;
        else chain_pull[k-12] <= v;
        repeat (HOLD) @(posedge aclk); // 1.5 us at 5 ns
    endtask
endmodule // iae_ext_src

// ---- iae_irq_assertions.sv ----
// checker of interrupt output and bus answer timing
`timescale 1ns/10ps
module iae_irq_chk #(
    parameter N_TRIG  = 12,
    parameter N_CHAIN = 8
) (
    // clock and reset
    input wire               aclk,
    input wire               aresetn,
    // bus handshakes
    input wire               s_axi_awvalid,
    input wire               s_axi_awready,
    input wire               s_axi_wvalid,
    input wire               s_axi_bvalid,
    input wire               s_axi_arvalid,
    input wire               s_axi_arready,
    input wire               s_axi_rvalid,
    // pins and interrupt
    input wire [N_TRIG-1:0]  trig_in,
    input wire [N_CHAIN-1:0] chain_shared_interrupt_oe,
    input wire               host_irq,
    input wire [4:0]         host_vector
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_aw_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    property p_rst_quiet;
        $rose(aresetn) |-> !host_irq && chain_shared_interrupt_oe == '0;
    endproperty
    property p_vec_idle;
        !host_irq |-> host_vector == 5'h00;
    endproperty
    property p_vec_range;
        host_irq |-> host_vector < 5'h14;
    endproperty
    // only a register write can withdraw a pending interrupt
    property p_irq_hold;
        host_irq && !s_axi_bvalid |=> host_irq;
    endproperty
    property p_oe_quiet;
        ($stable(trig_in) && !s_axi_wvalid) [*8] |-> $stable(chain_shared_interrupt_oe);
    endproperty
    property p_sync;
        $changed(trig_in) |=> $stable(chain_shared_interrupt_oe) [*2];
    endproperty
    property p_b_answer;
        s_aw_taken |-> ##[1:4] s_axi_bvalid;
    endproperty
    property p_r_answer;
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("active output after reset");
    a_vec_idle: assert property (p_vec_idle) else $error("vector without interrupt");
    a_vec_range: assert property (p_vec_range) else $error("vector out of range");
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped alone");
    a_oe_quiet: assert property (p_oe_quiet) else $error("chain drive changed alone");
    a_sync: assert property (p_sync) else $error("input not synchronised");
    a_b_answer: assert property (p_b_answer) else $error("write not answered");
    a_r_answer: assert property (p_r_answer) else $error("read not answered");
endmodule // iae_irq_chk

bind iae_irq_ctrl iae_irq_chk #(.N_TRIG(N_TRIG), .N_CHAIN(N_CHAIN)) chk_u (.*);

// ---- interrupt_arm_enable_logic_tb.sv ----
// self-checking bench for the interrupt arm/enable block
`timescale 1ns/10ps
`include "iae_regs.vh"
module interrupt_arm_enable_logic_tb;
    logic        aclk, aresetn, pps_in, host_irq;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr, pull, oe, lvl, cout;
    logic [31:0] wdata, rdata, rdata_q;
    logic [1:0]  bresp, rresp, rresp_q, bresp_q;
    logic [11:0] trig;
    logic [4:0]  vec;
    int          n_mismatch = 0, tests_run = 0, cyc = 0;
    // open-drain chain: any party pulling makes the line low
    assign lvl = ~(oe | pull);
    iae_ext_src src_u (.aclk(aclk), .trig(trig), .chain_pull(pull));
    iae_irq_ctrl dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .trig_in(trig), .chain_shared_interrupt_in(lvl), .chain_shared_interrupt_out(cout),
        .chain_shared_interrupt_oe(oe), .pps_in(pps_in), .host_irq(host_irq), .host_vector(vec));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        bresp_q = bresp;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rdata_q = rdata;
        rresp_q = rresp;
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rdata_q, e);
    endtask
    task t_reset;
        rc(`IAE_ARM_OFS, 32'h0);
        rc(`IAE_ENABLE_OFS, 32'h0);
        rc(`IAE_POL_OFS, 32'h000FFFFF);
        rc(`IAE_MODE_OFS, 32'h0);
        rd(8'h28);
        chk(rresp_q, `IAE_RESP_SLVERR);
        wr(8'h28, 32'h1);
        chk(bresp_q, `IAE_RESP_SLVERR);
        rc(`IAE_ARM_OFS, 32'h0);
    endtask
    task t_edge;
        wr(`IAE_ARM_OFS, 32'h1);
        chk(bresp_q, `IAE_RESP_OKAY);
        wr(`IAE_ENABLE_OFS, 32'h1);
        src_u.drive(0, 1'b1);
        chk(host_irq, 1'b1);
        rc(`IAE_PEND_OFS, 32'h1);
        wr(`IAE_PEND_OFS, 32'h1);
        rc(`IAE_PEND_OFS, 32'h0);
        chk(host_irq, 1'b0);
        src_u.drive(0, 1'b0);
        src_u.drive(0, 1'b1);
        rc(`IAE_PEND_OFS, 32'h1);
    endtask
    task t_hold;
        wr(`IAE_ENABLE_OFS, 32'h0);
        rc(`IAE_PEND_OFS, 32'h1);
        chk(host_irq, 1'b0);
        wr(`IAE_ENABLE_OFS, 32'h1);
        rc(`IAE_PEND_OFS, 32'h1);
        chk(host_irq, 1'b1);
        wr(`IAE_ARM_OFS, 32'h0);
        src_u.drive(0, 1'b0);
        src_u.drive(0, 1'b1);
        rc(`IAE_PEND_OFS, 32'h0);
    endtask
    task t_route;
        wr(`IAE_ROUTE_OFS, 32'h8); // one driver per chain line
        wr(`IAE_ARM_OFS, 32'h8);
        wr(`IAE_ENABLE_OFS, 32'h8);
        wr(`IAE_SWREQ_OFS, 32'h8);
        rc(`IAE_PEND_OFS, 32'h8);
        chk(vec, 5'h03);
        rc(`IAE_VECTOR_OFS, 32'h23);
        chk(oe, 8'h00);
        src_u.drive(3, 1'b1);
        chk(oe, 8'h08);
        chk(cout, 8'h00);
        src_u.drive(3, 1'b0);
        chk(oe, 8'h00);
    endtask
    task t_level;
        wr(`IAE_POL_OFS, 32'h000FFFFD);
        wr(`IAE_MODE_OFS, 32'h2);
        wr(`IAE_ARM_OFS, 32'h2);
        wr(`IAE_ENABLE_OFS, 32'h2);
        wr(`IAE_PEND_OFS, 32'h2);
        rc(`IAE_PEND_OFS, 32'h2);
        chk(vec, 5'h01);
        src_u.drive(1, 1'b1);
        wr(`IAE_PEND_OFS, 32'h2);
        rc(`IAE_PEND_OFS, 32'h0);
    endtask
    task t_chain;
        src_u.drive(12, 1'b1);
        src_u.drive(12, 1'b0);
        rc(`IAE_PEND_OFS, 32'h0);
        wr(`IAE_ARM_OFS, 32'h1000);
        wr(`IAE_ENABLE_OFS, 32'h1000);
        src_u.drive(12, 1'b1);
        src_u.drive(12, 1'b0);
        rc(`IAE_PEND_OFS, 32'h1000);
        chk(vec, 5'h0C);
        pps_in <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(`IAE_CAPTURE_OFS);
        chk(rdata_q != 0, 1'b1);
        repeat (8) @(posedge aclk);
        rc(`IAE_CAPTURE_OFS, rdata_q);
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // whole run needs about 3800 cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            finish_test;
        end
    end
    initial begin
        {aresetn, pps_in, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_edge;
        t_hold;
        t_route;
        t_level;
        t_chain;
        finish_test;
    end
endmodule // interrupt_arm_enable_logic_tb
